// ==== design/mpio_ports.sv ====
// Six parallel I/O ports behind an AXI4-Lite register slave.
// Behaviour
// - Output data sits in latches; pin reads return the pin level after the two-stage synchroniser.
// - Pin levels are sampled in the first cycle of a register read.
// - A write updates the latch and pin in the second cycle.
// - Port 1 bits with segment select set drive segment data.
// - Reset sets latches of ports 1, 2, 5 and 7 to all ones.
// - Ports 1, 2, 3, 5 and 7 have separate latch read and pin read addresses; port 6 has a latch read and a direction read.
// - Pin reads of segment bits may return any value.
// - Port 2 has three bits; upper read bits are undefined.
// - Dual-clock mode reserves port 2 bits one and two for the crystal.
// - A falling edge on driven port 2 bit zero sets the event latch.
// - Stop mode floats port 2 bit zero regardless of the drive gate.
// - Port 3 bits are open-drain when drive type is zero, else push-pull.
// - Reset sets port 3 latch to ones and drive type to zero.
// - Port 3 has four bits; upper read bits are undefined.
// - Port 6 mode: direction one output, else latch picks digital or analog.
// - Reset clears port 6 direction and latch, sets analog disable.
// - Port 6 bits in analog mode read as zero.
// - Ports 5 and 7 bits with segment select set drive segment data.
`timescale 1ns/1ps
module mpio_ports #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  input wire logic [2:0] port2_pin_in,
  output logic [2:0] port2_pin_out,
  output logic [2:0] port2_pin_oe,
  input wire logic [3:0] port3_pin_in,
  output logic [3:0] port3_pin_out,
  output logic [3:0] port3_pin_oe,
  input wire logic [7:0] port5_pin_in,
  output logic [7:0] port5_pin_out,
  output logic [7:0] port5_pin_oe,
  input wire logic [7:0] port6_pin_in,
  output logic [7:0] port6_pin_out,
  output logic [7:0] port6_pin_oe,
  input wire logic [7:0] port7_pin_in,
  output logic [7:0] port7_pin_out,
  output logic [7:0] port7_pin_oe,
  input wire logic [7:0] port1_seg_data,
  input wire logic [7:0] port5_seg_data,
  input wire logic [7:0] port7_seg_data,
  output logic [7:0] port6_analog_sel,
  output logic [7:0] port6_in_data,
  output logic port2_edge_flag
);
  typedef enum logic [1:0] {W_IDLE, W_APPLY, W_RESP} mpio_wst_t;
  typedef struct packed {
    mpio_wst_t wst;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-3:0] widx;
    logic [7:0] wdata;
    logic wen;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] port1_out_latch;
    logic [2:0] port2_out_latch;
    logic [3:0] port3_out_latch;
    logic [3:0] port3_drive_type;
    logic [7:0] port5_out_latch;
    logic [7:0] port6_out_latch;
    logic [7:0] port6_direction;
    logic [7:0] port7_out_latch;
    logic analog_input_disable;
    logic [7:0] port1_segment_sel;
    logic [7:0] port5_segment_sel;
    logic [7:0] port7_segment_sel;
    logic global_drive_gate;
    logic dual_clock;
    logic stop_mode;
  } mpio_state_t;

  mpio_state_t st;
  mpio_state_t next_st;
  mpio_sync_if #(.W(mpio_pkg::PIN_W)) sif ();
  logic [7:0] port1_pin;
  logic [2:0] port2_pin;
  logic [3:0] port3_pin;
  logic [7:0] port5_pin;
  logic [7:0] port6_pin;
  logic [7:0] port7_pin;
  logic [7:0] port6_read;
  logic p20_level;
  logic ev_clear;
  logic [ADDR_W-3:0] aridx;

  if (ADDR_W < 11) begin : g_chk
    $error("Address width must be at least 11 bits.");
  end

  function automatic logic is_mapped(input logic [ADDR_W-3:0] idx);
    logic ok;
    ok = 1'b0;
    case (idx[mpio_pkg::IDX_W-1:0])
      mpio_pkg::IDX_P1_LATCH, mpio_pkg::IDX_P2_LATCH, mpio_pkg::IDX_P3_LATCH,
      mpio_pkg::IDX_P3_TYPE, mpio_pkg::IDX_P5_LATCH, mpio_pkg::IDX_P6_LATCH,
      mpio_pkg::IDX_P7_LATCH, mpio_pkg::IDX_P1_PIN, mpio_pkg::IDX_P2_PIN,
      mpio_pkg::IDX_P3_PIN, mpio_pkg::IDX_P5_PIN, mpio_pkg::IDX_P6_DIR,
      mpio_pkg::IDX_P7_PIN, mpio_pkg::IDX_AIN, mpio_pkg::IDX_P1_SEG,
      mpio_pkg::IDX_P5_SEG, mpio_pkg::IDX_P7_SEG, mpio_pkg::IDX_CTRL,
      mpio_pkg::IDX_EVENT: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok && (idx[ADDR_W-3:mpio_pkg::IDX_W] == '0);
  endfunction : is_mapped

  // Pins pass two flip-flops before any logic reads them.
  assign sif.raw = {port7_pin_in, port6_pin_in, port5_pin_in, port3_pin_in, port2_pin_in, port1_pin_in};
  mpio_sync #(.W(mpio_pkg::PIN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sif(sif)
  );
  assign port1_pin = sif.synced[mpio_pkg::SYN_P1 +: 8];
  assign port2_pin = sif.synced[mpio_pkg::SYN_P2 +: 3];
  assign port3_pin = sif.synced[mpio_pkg::SYN_P3 +: 4];
  assign port5_pin = sif.synced[mpio_pkg::SYN_P5 +: 8];
  assign port6_pin = sif.synced[mpio_pkg::SYN_P6 +: 8];
  assign port7_pin = sif.synced[mpio_pkg::SYN_P7 +: 8];

  // Segment bits drive segment data; other port 1, 5 and 7 bits, and port 2 bits not floated by dual-clock or stop mode, pull low on zero and release on one.
  always_comb begin
    port1_pin_out = (st.port1_segment_sel & port1_seg_data) | (~st.port1_segment_sel & st.port1_out_latch);
    port1_pin_oe = {8{st.global_drive_gate}} & (st.port1_segment_sel | ~st.port1_out_latch);
    port5_pin_out = (st.port5_segment_sel & port5_seg_data) | (~st.port5_segment_sel & st.port5_out_latch);
    port5_pin_oe = {8{st.global_drive_gate}} & (st.port5_segment_sel | ~st.port5_out_latch);
    port7_pin_out = (st.port7_segment_sel & port7_seg_data) | (~st.port7_segment_sel & st.port7_out_latch);
    port7_pin_oe = {8{st.global_drive_gate}} & (st.port7_segment_sel | ~st.port7_out_latch);
    port2_pin_out = st.port2_out_latch;
    port2_pin_oe = {3{st.global_drive_gate}} & ~st.port2_out_latch;
    if (st.dual_clock) begin
      port2_pin_oe[2:1] = 2'h0;
    end
    if (st.stop_mode) begin
      port2_pin_oe[0] = 1'b0;
    end
    port3_pin_out = st.port3_out_latch;
    port3_pin_oe = {4{st.global_drive_gate}} & (st.port3_drive_type | ~st.port3_out_latch);
    port6_pin_out = st.port6_out_latch;
    port6_pin_oe = {8{st.global_drive_gate}} & st.port6_direction;
  end

  // Port 6 read: output bits show the latch, digital inputs the pin, analog bits zero.
  assign port6_read = (st.port6_direction & st.port6_out_latch) |
                      (~st.port6_direction & st.port6_out_latch & port6_pin);
  assign port6_in_data = ~st.port6_direction & st.port6_out_latch & port6_pin;
  assign port6_analog_sel = ~st.port6_direction & ~st.port6_out_latch & {8{~st.analog_input_disable}};

  // The edge latch follows the driven level while bit zero drives, else the pin.
  assign p20_level = port2_pin_oe[0] ? port2_pin_out[0] : port2_pin[0];
  assign ev_clear = (st.wst == W_APPLY) && st.wen && st.widx == (ADDR_W-2)'(mpio_pkg::IDX_EVENT) &&
                    st.wdata[mpio_pkg::EV_P20_BIT];
  mpio_edge_latch u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(p20_level),
    .clear(ev_clear),
    .flag(port2_edge_flag)
  );

  assign aridx = araddr[ADDR_W-1:2];
  assign awready = ce && st.wst == W_IDLE && !st.aw_got;
  assign wready = ce && st.wst == W_IDLE && !st.w_got;
  assign arready = ce && !st.rvalid;
  assign bvalid = st.wst == W_RESP;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = {24'h000000, st.rdata};

  always_comb begin
    logic [7:0] rd;
    logic [7:0] wd;
    rd = 8'h00;
    wd = st.wdata;
    next_st = st;
    if (ce) begin
      case (st.wst)
        W_IDLE: begin
          if (awvalid && !st.aw_got) begin
            next_st.aw_got = 1'b1;
            next_st.widx = awaddr[ADDR_W-1:2];
          end
          if (wvalid && !st.w_got) begin
            next_st.w_got = 1'b1;
            next_st.wdata = wdata[7:0];
            next_st.wen = wstrb[0];
          end
          if (next_st.aw_got && next_st.w_got) begin
            next_st.wst = W_APPLY;
          end
        end
        W_APPLY: begin
          next_st.aw_got = 1'b0;
          next_st.w_got = 1'b0;
          next_st.wst = W_RESP;
          next_st.bresp = is_mapped(st.widx) ? mpio_pkg::RESP_OKAY : mpio_pkg::RESP_SLVERR;
          if (st.wen && is_mapped(st.widx)) begin
            case (st.widx[mpio_pkg::IDX_W-1:0])
              mpio_pkg::IDX_P1_LATCH: next_st.port1_out_latch = wd;
              mpio_pkg::IDX_P2_LATCH: next_st.port2_out_latch = wd[2:0];
              mpio_pkg::IDX_P3_LATCH: next_st.port3_out_latch = wd[3:0];
              mpio_pkg::IDX_P3_TYPE: next_st.port3_drive_type = wd[3:0];
              mpio_pkg::IDX_P5_LATCH: next_st.port5_out_latch = wd;
              mpio_pkg::IDX_P6_LATCH: next_st.port6_out_latch = wd;
              mpio_pkg::IDX_P7_LATCH: next_st.port7_out_latch = wd;
              mpio_pkg::IDX_P6_DIR: next_st.port6_direction = wd;
              mpio_pkg::IDX_AIN: next_st.analog_input_disable = wd[mpio_pkg::AIN_DIS_BIT];
              mpio_pkg::IDX_P1_SEG: next_st.port1_segment_sel = wd;
              mpio_pkg::IDX_P5_SEG: next_st.port5_segment_sel = wd;
              mpio_pkg::IDX_P7_SEG: next_st.port7_segment_sel = wd;
              mpio_pkg::IDX_CTRL: begin
                next_st.global_drive_gate = wd[mpio_pkg::CTRL_GATE_BIT];
                next_st.dual_clock = wd[mpio_pkg::CTRL_DUAL_BIT];
                next_st.stop_mode = wd[mpio_pkg::CTRL_STOP_BIT];
              end
              default: next_st.wst = W_RESP;
            endcase
          end
        end
        W_RESP: begin
          if (bready) begin
            next_st.wst = W_IDLE;
          end
        end
        default: next_st.wst = W_IDLE;
      endcase
      if (st.rvalid && rready) begin
        next_st.rvalid = 1'b0;
      end
      if (arvalid && !st.rvalid) begin
        case (aridx[mpio_pkg::IDX_W-1:0])
          mpio_pkg::IDX_P1_LATCH: rd = st.port1_out_latch;
          mpio_pkg::IDX_P2_LATCH: rd = {5'h00, st.port2_out_latch};
          mpio_pkg::IDX_P3_LATCH: rd = {4'h0, st.port3_out_latch};
          mpio_pkg::IDX_P3_TYPE: rd = {4'h0, st.port3_drive_type};
          mpio_pkg::IDX_P5_LATCH: rd = st.port5_out_latch;
          mpio_pkg::IDX_P6_LATCH: rd = port6_read;
          mpio_pkg::IDX_P7_LATCH: rd = st.port7_out_latch;
          mpio_pkg::IDX_P1_PIN: rd = port1_pin;
          mpio_pkg::IDX_P2_PIN: rd = {5'h00, port2_pin};
          mpio_pkg::IDX_P3_PIN: rd = {4'h0, port3_pin};
          mpio_pkg::IDX_P5_PIN: rd = port5_pin;
          mpio_pkg::IDX_P6_DIR: rd = st.port6_direction;
          mpio_pkg::IDX_P7_PIN: rd = port7_pin;
          mpio_pkg::IDX_AIN: rd = 8'(st.analog_input_disable) << mpio_pkg::AIN_DIS_BIT;
          mpio_pkg::IDX_P1_SEG: rd = st.port1_segment_sel;
          mpio_pkg::IDX_P5_SEG: rd = st.port5_segment_sel;
          mpio_pkg::IDX_P7_SEG: rd = st.port7_segment_sel;
          mpio_pkg::IDX_CTRL: begin
            rd[mpio_pkg::CTRL_GATE_BIT] = st.global_drive_gate;
            rd[mpio_pkg::CTRL_DUAL_BIT] = st.dual_clock;
            rd[mpio_pkg::CTRL_STOP_BIT] = st.stop_mode;
          end
          mpio_pkg::IDX_EVENT: rd[mpio_pkg::EV_P20_BIT] = port2_edge_flag;
          default: rd = 8'h00;
        endcase
        next_st.rvalid = 1'b1;
        next_st.rdata = is_mapped(aridx) ? rd : 8'h00;
        next_st.rresp = is_mapped(aridx) ? mpio_pkg::RESP_OKAY : mpio_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.wst <= W_IDLE;
      st.port1_out_latch <= mpio_pkg::RST_P8;
      st.port2_out_latch <= mpio_pkg::RST_P2;
      st.port3_out_latch <= mpio_pkg::RST_P3;
      st.port3_drive_type <= mpio_pkg::RST_P3_TYPE;
      st.port5_out_latch <= mpio_pkg::RST_P8;
      st.port7_out_latch <= mpio_pkg::RST_P8;
      st.port6_out_latch <= mpio_pkg::RST_P6;
      st.port6_direction <= mpio_pkg::RST_P6;
      st.analog_input_disable <= mpio_pkg::RST_AIN_DIS;
      st.port1_segment_sel <= mpio_pkg::RST_SEG;
      st.port5_segment_sel <= mpio_pkg::RST_SEG;
      st.port7_segment_sel <= mpio_pkg::RST_SEG;
      st.global_drive_gate <= mpio_pkg::RST_GATE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd(logic [7:0] idx);
    ce && arvalid && arready && aridx == (ADDR_W-2)'(idx);
  endsequence
  sequence s_apply(logic [7:0] idx);
    ce && st.wst == W_APPLY && st.wen && st.widx == (ADDR_W-2)'(idx);
  endsequence

  property p_latch_hold;
    (st.wst != W_APPLY) |=> $stable(st.port1_out_latch) && $stable(st.port7_out_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Port latch changed without a write.");
  property p_pin_sample;
    s_rd(mpio_pkg::IDX_P1_PIN) |=> rvalid && rdata[7:0] == $past(port1_pin);
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("Pin read did not return sampled level.");
  property p_write_second;
    s_apply(mpio_pkg::IDX_P1_LATCH) |=> port1_pin_out == ($past(st.wdata) & ~st.port1_segment_sel |
      port1_seg_data & st.port1_segment_sel) && bvalid;
  endproperty
  a_write_second: assert property (p_write_second) else $error("Latch write not seen in second cycle.");
  property p_seg_route;
    st.global_drive_gate |-> ((port1_pin_oe & st.port1_segment_sel) == st.port1_segment_sel) &&
      ((port1_pin_out & st.port1_segment_sel) == (port1_seg_data & st.port1_segment_sel));
  endproperty
  a_seg_route: assert property (p_seg_route) else $error("Segment bit not driven from segment data.");
  property p_reset_vals;
    $rose(aresetn) |-> st.port1_out_latch == 8'hFF && st.port2_out_latch == 3'h7 &&
      st.port5_out_latch == 8'hFF && st.port7_out_latch == 8'hFF && st.port3_drive_type == 4'h0 &&
      st.port6_direction == 8'h00 && st.port6_out_latch == 8'h00 && st.analog_input_disable;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong.");
  property p_p2_width;
    s_rd(mpio_pkg::IDX_P2_PIN) |=> rdata[7:3] == 5'h00;
  endproperty
  a_p2_width: assert property (p_p2_width) else $error("Port 2 upper read bits not zero.");
  property p_dual_clock;
    st.dual_clock |-> port2_pin_oe[2:1] == 2'h0;
  endproperty
  a_dual_clock: assert property (p_dual_clock) else $error("Crystal pins driven in dual-clock mode.");
  property p_edge_set;
    ce && $past(ce) && $fell(p20_level) |=> port2_edge_flag;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("Falling edge did not set the event latch.");
  property p_stop_float;
    st.stop_mode |-> !port2_pin_oe[0];
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("Bit zero driven in stop mode.");
  property p_open_drain;
    st.global_drive_gate |-> port3_pin_oe == (st.port3_drive_type | ~st.port3_out_latch);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Port 3 drive type ignored.");
  property p_analog_zero;
    s_rd(mpio_pkg::IDX_P6_LATCH) |=> (rdata[7:0] & $past(~st.port6_direction & ~st.port6_out_latch)) == 8'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("Analog bit read as nonzero.");
endmodule : mpio_ports

// ==== design/mpio_pkg.sv ====
// Shared constants for the multi-port parallel I/O block.
package mpio_pkg;
  localparam int IDX_W = 8;
  localparam logic [7:0] IDX_P1_LATCH = 8'h01;
  localparam logic [7:0] IDX_P2_LATCH = 8'h02;
  localparam logic [7:0] IDX_P3_LATCH = 8'h03;
  localparam logic [7:0] IDX_P3_TYPE = 8'h04;
  localparam logic [7:0] IDX_P5_LATCH = 8'h05;
  localparam logic [7:0] IDX_P6_LATCH = 8'h06;
  localparam logic [7:0] IDX_P7_LATCH = 8'h07;
  localparam logic [7:0] IDX_P1_PIN = 8'h08;
  localparam logic [7:0] IDX_P2_PIN = 8'h09;
  localparam logic [7:0] IDX_P3_PIN = 8'h0A;
  localparam logic [7:0] IDX_P5_PIN = 8'h0B;
  localparam logic [7:0] IDX_P6_DIR = 8'h0C;
  localparam logic [7:0] IDX_P7_PIN = 8'h0D;
  localparam logic [7:0] IDX_AIN = 8'h0E;
  localparam logic [7:0] IDX_P1_SEG = 8'h29;
  localparam logic [7:0] IDX_P5_SEG = 8'h2A;
  localparam logic [7:0] IDX_P7_SEG = 8'h2B;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_EVENT = 8'h41;
  localparam int AIN_DIS_BIT = 0;
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int EV_P20_BIT = 0;
  localparam int SYN_P1 = 0;
  localparam int SYN_P2 = 8;
  localparam int SYN_P3 = 11;
  localparam int SYN_P5 = 15;
  localparam int SYN_P6 = 23;
  localparam int SYN_P7 = 31;
  localparam int PIN_W = 39;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_P8 = 8'hFF;
  localparam logic [2:0] RST_P2 = 3'h7;
  localparam logic [3:0] RST_P3 = 4'hF;
  localparam logic [3:0] RST_P3_TYPE = 4'h0;
  localparam logic [7:0] RST_P6 = 8'h00;
  localparam logic [7:0] RST_SEG = 8'h00;
  localparam logic RST_AIN_DIS = 1'b1;
  localparam logic RST_GATE = 1'b1;
endpackage : mpio_pkg

// ==== design/mpio_sync_if.sv ====
// Carrier between the port logic and the pin synchroniser.
`timescale 1ns/1ps
interface mpio_sync_if #(parameter int W = 39);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport drv (output raw, input synced);
  modport syn (input raw, output synced);
endinterface : mpio_sync_if

// ==== design/mpio_sync.sv ====
// Two-stage synchroniser for all port pin inputs.
`timescale 1ns/1ps
module mpio_sync #(parameter int W = 39) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  mpio_sync_if.syn sif
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mpio_sync_st_t;
  mpio_sync_st_t st;
  mpio_sync_st_t next_st;

  if (W < 1) begin : g_chk
    $error("Synchroniser width must be positive.");
  end

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.s1 = sif.raw;
      next_st.s2 = st.s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.synced = st.s2;
endmodule : mpio_sync

// ==== design/mpio_edge_latch.sv ====
// Sticky falling-edge latch with a clear where a new edge wins.
`timescale 1ns/1ps
module mpio_edge_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic level,
  input wire logic clear,
  output logic flag
);
  typedef struct packed {
    logic prev;
    logic flag;
  } mpio_edge_st_t;
  mpio_edge_st_t st;
  mpio_edge_st_t next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.prev = level;
      if (st.prev && !level) begin
        next_st.flag = 1'b1;
      end else if (clear) begin
        next_st.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;
endmodule : mpio_edge_latch

// ==== dv/mpio_pins.sv ====
// Board model that resolves every port pin from the block's drive and the board level.
`timescale 1ns/1ps
module mpio_pins (
  input wire logic [38:0] oe,
  input wire logic [38:0] dout,
  input wire logic [38:0] ext,
  output logic [38:0] pin
);
  // A released pin falls back to the board level, which the bench keeps defined.
  assign pin = (oe & dout) | (~oe & ext);
endmodule : mpio_pins

// ==== dv/multi_port_parallel_io_tb.sv ====
// Self-checking bench for the parallel I/O port block.
`timescale 1ns/1ps
module multi_port_parallel_io_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] seg, p6_ana, p6_in;
  logic [38:0] oe, dout, ext, pin;
  logic flag;
  int fail_count, cmp_count;
  mpio_ports uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port1_pin_in(pin[7:0]), .port1_pin_out(dout[7:0]), .port1_pin_oe(oe[7:0]),
    .port2_pin_in(pin[10:8]), .port2_pin_out(dout[10:8]), .port2_pin_oe(oe[10:8]),
    .port3_pin_in(pin[14:11]), .port3_pin_out(dout[14:11]), .port3_pin_oe(oe[14:11]),
    .port5_pin_in(pin[22:15]), .port5_pin_out(dout[22:15]), .port5_pin_oe(oe[22:15]),
    .port6_pin_in(pin[30:23]), .port6_pin_out(dout[30:23]), .port6_pin_oe(oe[30:23]),
    .port7_pin_in(pin[38:31]), .port7_pin_out(dout[38:31]), .port7_pin_oe(oe[38:31]),
    .port1_seg_data(seg), .port5_seg_data(seg), .port7_seg_data(seg),
    .port6_analog_sel(p6_ana), .port6_in_data(p6_in), .port2_edge_flag(flag));
  mpio_pins board (.oe(oe), .dout(dout), .ext(ext), .pin(pin));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
    logic a, w, b;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end while (b !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (b !== 1'b1) chk({31'h0, b}, 32'h1);
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    logic a, v;
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      a = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      n++;
    end while (v !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (v !== 1'b1) chk({31'h0, v}, 32'h1);
  endtask : rd
  task automatic wc(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr(i, d, r);
    chk({30'h0, r}, {30'h0, mpio_pkg::RESP_OKAY});
  endtask : wc
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, mpio_pkg::RESP_OKAY});
  endtask : rc
  task automatic t_reset;
    rc(mpio_pkg::IDX_P1_LATCH, 8'hFF);
    rc(mpio_pkg::IDX_P2_LATCH, 8'h07);
    rc(mpio_pkg::IDX_P5_LATCH, 8'hFF);
    rc(mpio_pkg::IDX_P7_LATCH, 8'hFF);
    rc(mpio_pkg::IDX_P3_LATCH, 8'h0F);
    rc(mpio_pkg::IDX_P3_TYPE, 8'h00);
    rc(mpio_pkg::IDX_P6_LATCH, 8'h00);
    rc(mpio_pkg::IDX_P6_DIR, 8'h00);
    rc(mpio_pkg::IDX_AIN, 8'h01);
    chk({24'h0, p6_in}, 32'h0);
  endtask : t_reset
  task automatic t_latch;
    wc(mpio_pkg::IDX_P1_LATCH, 8'hA5);
    chk({16'h0, dout[7:0], oe[7:0]}, 32'hA55A);
    ext[7:0] <= 8'h0F;
    repeat (4) @(posedge aclk);
    rc(mpio_pkg::IDX_P1_PIN, 8'h05);
    rc(mpio_pkg::IDX_P1_LATCH, 8'hA5);
  endtask : t_latch
  task automatic t_p3;
    wc(mpio_pkg::IDX_P3_TYPE, 8'h03);
    wc(mpio_pkg::IDX_P3_LATCH, 8'h05);
    chk({24'h0, dout[14:11], oe[14:11]}, 32'h5B);
    rc(mpio_pkg::IDX_P3_PIN, 8'h05);
  endtask : t_p3
  task automatic t_p6;
    wc(mpio_pkg::IDX_AIN, 8'h00);
    wc(mpio_pkg::IDX_P6_DIR, 8'h80);
    wc(mpio_pkg::IDX_P6_LATCH, 8'h8F);
    ext[30:23] <= 8'h3C;
    repeat (4) @(posedge aclk);
    chk({8'h0, oe[30:23], p6_ana, p6_in}, 32'h80700C);
    rc(mpio_pkg::IDX_P6_LATCH, 8'h8C);
  endtask : t_p6
  task automatic t_seg;
    seg <= 8'h36;
    wc(mpio_pkg::IDX_P1_SEG, 8'h0F);
    chk({16'h0, dout[7:0], oe[7:0]}, 32'hA65F);
    wc(mpio_pkg::IDX_P5_SEG, 8'hF0);
    chk({16'h0, dout[22:15], oe[22:15]}, 32'h3FF0);
    wc(mpio_pkg::IDX_P7_SEG, 8'h81);
    chk({16'h0, dout[38:31], oe[38:31]}, 32'h7E81);
    rc(mpio_pkg::IDX_P7_PIN, 8'h7E);
  endtask : t_seg
  task automatic t_p2;
    wc(mpio_pkg::IDX_P2_LATCH, 8'h06);
    repeat (2) @(posedge aclk);
    chk({31'h0, flag}, 32'h1);
    rc(mpio_pkg::IDX_EVENT, 8'h01);
    wc(mpio_pkg::IDX_EVENT, 8'h01);
    rc(mpio_pkg::IDX_EVENT, 8'h00);
    wc(mpio_pkg::IDX_P2_LATCH, 8'h00);
    wc(mpio_pkg::IDX_CTRL, 8'h03);
    chk({29'h0, oe[10:8]}, 32'h1);
    wc(mpio_pkg::IDX_CTRL, 8'h07);
    chk({29'h0, oe[10:8]}, 32'h0);
    rc(mpio_pkg::IDX_P2_PIN, 8'h07);
  endtask : t_p2
  task automatic t_err;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h3F, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, mpio_pkg::RESP_SLVERR});
    wr(8'h3F, 8'h00, r);
    chk({30'h0, r}, {30'h0, mpio_pkg::RESP_SLVERR});
    wc(mpio_pkg::IDX_P1_PIN, 8'h00);
    rc(mpio_pkg::IDX_P1_LATCH, 8'hA5);
  endtask : t_err
  task automatic t_rerun;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(mpio_pkg::IDX_P1_LATCH, 8'hFF);
    rc(mpio_pkg::IDX_P3_TYPE, 8'h00);
    rc(mpio_pkg::IDX_P6_DIR, 8'h00);
  endtask : t_rerun
  task automatic print_verdict;
    $display("errors %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, seg} = '0;
    ext = '1;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_latch();
    t_p3();
    t_p6();
    t_seg();
    t_p2();
    t_err();
    t_rerun();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    $display("unexpected at %0t: timeout", $time);
    fail_count++;
    print_verdict();
  end
endmodule : multi_port_parallel_io_tb
